/* bst_pkg.sv */
// Constants shared by the boundary-scan test port.
// Assumes a 4-bit instruction register and a 32-bit shared data shifter.
// How it works
// - Scan test instructions fall back to bypass while the core reports configuration busy.
// - Sample/preload captures pins and probes and loads a pattern that is held for later driving.
// - External test drives the held pattern onto the pins and captures the pin inputs.
// - Bypass puts one bit, captured as zero, between TDI and TDO.
// - User code puts a 32-bit register holding the user value between TDI and TDO.
// - Identification puts the identity register between TDI and TDO.
// - The configuration instruction shifts words in that are handed to the core's loader.
// - The analyzer instruction shifts out the probe signals; sample/preload also carries them.
// - A reduced build keeps only bypass and the analyzer instruction.
package bst_pkg;
    localparam int IR_W = 4;
    localparam logic [IR_W-1:0] OP_EXTEST = 4'h0;
    localparam logic [IR_W-1:0] OP_CFG_LOAD = 4'h2;
    localparam logic [IR_W-1:0] OP_SAMPLE = 4'h5;
    localparam logic [IR_W-1:0] OP_IDCODE = 4'h6;
    localparam logic [IR_W-1:0] OP_USERCODE = 4'h7;
    localparam logic [IR_W-1:0] OP_LA_PROBE = 4'h8;
    localparam logic [IR_W-1:0] OP_BYPASS = 4'hf;
    // Instruction capture pattern, low bits 01
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    localparam int DR_W = 32;
    localparam int USER_W = 32;
    localparam int ID_W = 32;
    localparam int BYP_W = 1;
    localparam int CFG_W = 32;
    localparam int FIFO_DEPTH = 8;
    // Identity value is arbitrary
    localparam logic [ID_W-1:0] ID_DEFAULT = 32'h0a5c_0001;
    localparam logic [USER_W-1:0] USER_DEFAULT = 32'h0000_0000;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } bst_tap_e;

    typedef enum logic [2:0] {
        DR_BYP, DR_ID, DR_USER, DR_BSR, DR_CFG, DR_LA
    } bst_dr_e;
endpackage

/* bst_port.sv */
// Boundary-scan test port with configuration loader path and probe chain.
// Assumes TCK from the test controller, MCLK for the core side, and the
// core loader draining configuration words with valid/ready.
`timescale 1ns/100ps
`default_nettype none

// Single-clock FIFO for configuration words
module bst_fifo #(
    parameter int W = 32,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // Honest full and empty from the fill count
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers wrap at the depth, not the power of two
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
        end
    end

    // Fill count
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule

module bst_port #(
    parameter int PIN_W = 8,
    parameter int PROBE_W = 8,
    parameter bit HAS_BSCAN = 1'b1,
    parameter logic [bst_pkg::ID_W-1:0] ID_CODE = bst_pkg::ID_DEFAULT,
    parameter logic [bst_pkg::USER_W-1:0] USER_CODE = bst_pkg::USER_DEFAULT
) (
    // Core clock and reset
    input wire logic MCLK,
    input wire logic NRST,
    // Test port
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    output logic TDO,
    output logic TDO_OE,
    // Device pins under test
    input wire logic [PIN_W-1:0] PIN_IN,
    output logic [PIN_W-1:0] PIN_OUT,
    output logic PIN_DRIVE,
    // Core status and probes
    input wire logic CONF_BUSY,
    input wire logic [PROBE_W-1:0] PROBE,
    // Configuration words to the core loader
    output logic CFG_VALID,
    input wire logic CFG_READY,
    output logic [bst_pkg::CFG_W-1:0] CFG_DATA
);
    import bst_pkg::*;

    localparam int BSR_W = PIN_W + PROBE_W;
    localparam int LW = $clog2(DR_W + 1);

    bst_tap_e st_q;
    logic rst_m_q;
    logic rst_t_q;
    logic trst;
    logic busy_m_q;
    logic busy_t_q;
    logic [PIN_W-1:0] pin_m_q;
    logic [PIN_W-1:0] pin_t_q;
    logic [PROBE_W-1:0] prb_m_q;
    logic [PROBE_W-1:0] prb_t_q;
    logic [IR_W-1:0] ir_sh_q;
    logic [IR_W-1:0] ir_q;
    logic [DR_W-1:0] dr_q;
    logic [DR_W-1:0] cap_d;
    logic [PIN_W-1:0] upd_q;
    bst_dr_e sel;
    logic [LW-1:0] len;
    logic [CFG_W-1:0] word_q;
    logic req_q;
    logic ack_m_q;
    logic ack_t_q;
    logic pend;
    logic req_a_q;
    logic req_b_q;
    logic req_c_q;
    logic ack_q;
    logic took_q;
    logic f_valid;
    logic f_ready;
    logic o_valid;
    logic o_ready;
    logic [CFG_W-1:0] o_data;

    // TAP next state from TMS
    function automatic bst_tap_e tap_next(input bst_tap_e s, input logic tms);
        case (s)
            TLR: tap_next = tms ? TLR : RTI;
            RTI: tap_next = tms ? SEL_DR : RTI;
            SEL_DR: tap_next = tms ? SEL_IR : CAP_DR;
            CAP_DR: tap_next = tms ? EX1_DR : SH_DR;
            SH_DR: tap_next = tms ? EX1_DR : SH_DR;
            EX1_DR: tap_next = tms ? UPD_DR : PA_DR;
            PA_DR: tap_next = tms ? EX2_DR : PA_DR;
            EX2_DR: tap_next = tms ? UPD_DR : SH_DR;
            UPD_DR: tap_next = tms ? SEL_DR : RTI;
            SEL_IR: tap_next = tms ? TLR : CAP_IR;
            CAP_IR: tap_next = tms ? EX1_IR : SH_IR;
            SH_IR: tap_next = tms ? EX1_IR : SH_IR;
            EX1_IR: tap_next = tms ? UPD_IR : PA_IR;
            PA_IR: tap_next = tms ? EX2_IR : PA_IR;
            EX2_IR: tap_next = tms ? UPD_IR : SH_IR;
            UPD_IR: tap_next = tms ? SEL_DR : RTI;
            default: tap_next = TLR;
        endcase
    endfunction

    // Instruction to data register; unknown opcodes act as bypass
    function automatic bst_dr_e dr_of(input logic [IR_W-1:0] op, input logic busy);
        dr_of = DR_BYP;
        if (op == OP_LA_PROBE) begin
            dr_of = DR_LA;
        end else if (HAS_BSCAN) begin
            case (op)
                OP_IDCODE: dr_of = DR_ID;
                OP_USERCODE: dr_of = DR_USER;
                OP_CFG_LOAD: dr_of = DR_CFG;
                OP_EXTEST, OP_SAMPLE: dr_of = busy ? DR_BYP : DR_BSR;
                default: dr_of = DR_BYP;
            endcase
        end
    endfunction

    // Chain length per selected register
    function automatic logic [LW-1:0] len_of(input bst_dr_e d);
        case (d)
            DR_ID: len_of = LW'(ID_W);
            DR_USER: len_of = LW'(USER_W);
            DR_BSR: len_of = LW'(BSR_W);
            DR_CFG: len_of = LW'(CFG_W);
            DR_LA: len_of = LW'(PROBE_W);
            default: len_of = LW'(BYP_W);
        endcase
    endfunction

    // Reset into TCK; first flop feeds only the second
    always_ff @(posedge TCK) begin
        rst_m_q <= NRST;
        rst_t_q <= rst_m_q;
    end
    assign trst = !rst_t_q;

    // Pins, probes and busy cross into TCK through two flops each
    always_ff @(posedge TCK) begin
        pin_m_q <= PIN_IN;
        pin_t_q <= pin_m_q;
        prb_m_q <= PROBE;
        prb_t_q <= prb_m_q;
        busy_m_q <= CONF_BUSY;
        busy_t_q <= busy_m_q;
    end

    // TAP state machine
    always_ff @(posedge TCK) begin
        if (trst) begin
            st_q <= TLR;
        end else begin
            st_q <= tap_next(st_q, TMS);
        end
    end

    // Instruction register; reset selects identification
    always_ff @(posedge TCK) begin
        if (trst || st_q == TLR) begin
            ir_sh_q <= IR_CAPTURE;
            ir_q <= OP_IDCODE;
        end else if (st_q == CAP_IR) begin
            ir_sh_q <= IR_CAPTURE;
        end else if (st_q == SH_IR) begin
            ir_sh_q <= {TDI, ir_sh_q[IR_W-1:1]};
        end else if (st_q == UPD_IR) begin
            ir_q <= ir_sh_q;
        end
    end

    assign sel = dr_of(ir_q, busy_t_q);
    assign len = len_of(sel);

    // Capture values; bypass captures zero
    always_comb begin
        cap_d = '0;
        case (sel)
            DR_ID: cap_d[ID_W-1:0] = ID_CODE;
            DR_USER: cap_d[USER_W-1:0] = USER_CODE;
            DR_BSR: cap_d[BSR_W-1:0] = {prb_t_q, pin_t_q};
            DR_CFG: cap_d[0] = pend; // Shows a word still in flight
            DR_LA: cap_d[PROBE_W-1:0] = prb_t_q;
            default: cap_d = '0;
        endcase
    end

    // Shared data shifter; TDI enters at the selected length
    always_ff @(posedge TCK) begin
        if (trst) begin
            dr_q <= '0;
        end else if (st_q == CAP_DR) begin
            dr_q <= cap_d;
        end else if (st_q == SH_DR) begin
            for (int i = 0; i < DR_W; i++) begin
                if (i == int'(len) - 1) begin
                    dr_q[i] <= TDI;
                end else if (i < DR_W - 1) begin
                    dr_q[i] <= dr_q[i+1];
                end else begin
                    dr_q[i] <= 1'b0;
                end
            end
        end
    end

    // Held pin pattern, loaded by preload or external test
    always_ff @(posedge TCK) begin
        if (trst) begin
            upd_q <= '0;
        end else if (st_q == UPD_DR && sel == DR_BSR) begin
            upd_q <= dr_q[PIN_W-1:0];
        end
    end

    // PIN_OUT always follows the pattern; PIN_DRIVE is raised only under external test
    always_ff @(posedge TCK) begin
        if (trst) begin
            PIN_OUT <= '0;
            PIN_DRIVE <= 1'b0;
        end else begin
            PIN_OUT <= upd_q;
            PIN_DRIVE <= (ir_q == OP_EXTEST) && (sel == DR_BSR);
        end
    end

    // TDO changes on the falling edge, as the standard wants
    always_ff @(negedge TCK) begin
        if (trst) begin
            TDO <= 1'b0;
            TDO_OE <= 1'b0;
        end else begin
            TDO <= (st_q == SH_IR) ? ir_sh_q[0] : dr_q[0];
            TDO_OE <= (st_q == SH_IR) || (st_q == SH_DR);
        end
    end

    // Ack toggle back into TCK
    always_ff @(posedge TCK) begin
        ack_m_q <= ack_q;
        ack_t_q <= ack_m_q;
    end
    assign pend = (req_q != ack_t_q);

    // Config word held stable while the toggle is in flight;
    // a word updated while one is pending is dropped
    always_ff @(posedge TCK) begin
        if (trst) begin
            word_q <= '0;
            req_q <= 1'b0;
        end else if (st_q == UPD_DR && sel == DR_CFG && !pend) begin
            word_q <= dr_q[CFG_W-1:0];
            req_q <= !req_q;
        end
    end

    // Request toggle into MCLK; third flop finds the edge
    always_ff @(posedge MCLK) begin
        req_a_q <= req_q;
        req_b_q <= req_a_q;
    end

    // Word taken into the FIFO and acked on the same edge; ack waits on back-pressure
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            req_c_q <= 1'b0;
            ack_q <= 1'b0;
            took_q <= 1'b0;
        end else begin
            took_q <= 1'b0;
            if (f_valid && f_ready) begin
                req_c_q <= req_b_q;
                ack_q <= req_b_q;
                took_q <= 1'b1;
            end
        end
    end
    assign f_valid = (req_b_q != req_c_q) && !took_q;

    bst_fifo #(
        .W(CFG_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(MCLK),
        .rst_n(NRST),
        .in_valid(f_valid),
        .in_ready(f_ready),
        .in_data(word_q),
        .out_valid(o_valid),
        .out_ready(o_ready),
        .out_data(o_data)
    );

    // Output stage so the loader sees flops; stalls when held
    assign o_ready = !CFG_VALID || CFG_READY;
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            CFG_VALID <= 1'b0;
            CFG_DATA <= '0;
        end else if (o_ready) begin
            CFG_VALID <= o_valid;
            CFG_DATA <= o_data;
        end
    end
endmodule

`default_nettype wire

/* bst_jtag_ctl.sv */
// Test controller model that drives the scan port in frames.
// Assumes the port starts in Run-Test/Idle before each frame.
`timescale 1ns/100ps
`default_nettype none
module bst_jtag_ctl (
    // Test port lines
    output var logic TCK,
    output var logic TMS,
    output var logic TDI,
    input wire logic TDO
);
    logic got;
    // Test clock stands still low outside frames
    initial {TCK, TMS, TDI} = 3'b010;
    // One TCK cycle; lines change after the falling edge, TDO taken at rise
    task automatic tick(input logic m, input logic d);
        TMS = m;
        TDI = d;
        #7.5;
        TCK = 1'b1;
        got = TDO;
        #7.5;
        TCK = 1'b0;
    endtask
    // Idle cycles; TDI toggles since nothing samples it here
    task automatic idle(input int n, input logic m);
        repeat (n) tick(m, ~TDI);
    endtask
    // Full IR or DR frame from Run-Test/Idle back to it, LSB first
    task automatic scan(input bit ir, input int n, input logic [39:0] din,
                        output logic [39:0] dout);
        dout = '0;
        tick(1'b1, ~TDI);
        if (ir)
            tick(1'b1, ~TDI);
        idle(2, 1'b0);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i]);
            dout[i] = got;
        end
        tick(1'b1, ~TDI);
        tick(1'b0, ~TDI);
        // One more idle edge: pin outputs trail the update by a cycle
        tick(1'b0, ~TDI);
    endtask
endmodule
`default_nettype wire

/* bst_port_props.sv */
// Port-level checker for the boundary-scan test port.
// Assumes it is bound onto every instance of the port.
`timescale 1ns/100ps
`default_nettype none
module bst_port_props #(
    parameter int PIN_W = 8
) (
    // Clocks and reset
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic TCK,
    // Test port
    input wire logic TMS,
    input wire logic TDO,
    input wire logic TDO_OE,
    // Pins and core side
    input wire logic [PIN_W-1:0] PIN_OUT,
    input wire logic PIN_DRIVE,
    input wire logic CONF_BUSY,
    input wire logic CFG_VALID,
    input wire logic CFG_READY,
    input wire logic [bst_pkg::CFG_W-1:0] CFG_DATA
);
    import bst_pkg::*;
    // Reset is synced into TCK, so it needs a few edges to land
    sequence rst_held_s;
        !NRST [*5];
    endsequence
    sequence busy_held_s;
        CONF_BUSY [*5];
    endsequence
    sequence shift_leave_s;
        TDO_OE && TMS;
    endsequence
    cfg_hold_a: assert property (@(posedge MCLK) disable iff (!NRST)
        CFG_VALID && !CFG_READY |=> CFG_VALID && $stable(CFG_DATA))
        else $error("config word changed before it was taken");
    cfg_rst_a: assert property (@(posedge MCLK) !NRST |=> !CFG_VALID && CFG_DATA == '0)
        else $error("config output not cleared in reset");
    tck_rst_a: assert property (@(posedge TCK) rst_held_s |->
        !TDO_OE && !TDO && !PIN_DRIVE && PIN_OUT == '0)
        else $error("test port outputs not cleared in reset");
    tms_reset_a: assert property (@(posedge TCK) disable iff (!NRST)
        TMS [*6] |-> !TDO_OE)
        else $error("five TMS highs did not leave shift");
    oe_entry_a: assert property (@(posedge TCK) disable iff (!NRST)
        TDO_OE |-> !$past(TMS))
        else $error("TDO enabled outside a shift state");
    oe_exit_a: assert property (@(posedge TCK) disable iff (!NRST)
        shift_leave_s |=> !TDO_OE)
        else $error("TDO still enabled after leaving shift");
    busy_drive_a: assert property (@(posedge TCK) disable iff (!NRST)
        busy_held_s |=> !PIN_DRIVE)
        else $error("pins driven while configuration busy");
    pin_hold_a: assert property (@(posedge TCK) disable iff (!NRST)
        !$stable(PIN_OUT) |-> !TDO_OE && !$past(TDO_OE))
        else $error("pin pattern changed during a shift");
endmodule
bind bst_port bst_port_props #(.PIN_W(PIN_W)) u_bst_port_props (
    .MCLK(MCLK), .NRST(NRST), .TCK(TCK), .TMS(TMS), .TDO(TDO), .TDO_OE(TDO_OE),
    .PIN_OUT(PIN_OUT), .PIN_DRIVE(PIN_DRIVE), .CONF_BUSY(CONF_BUSY),
    .CFG_VALID(CFG_VALID), .CFG_READY(CFG_READY), .CFG_DATA(CFG_DATA)
);
`default_nettype wire

/* bst_port_tb_top.sv */
// Self-checking bench for the boundary-scan test port.
// Assumes the controller model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module bst_port_tb_top;
    import bst_pkg::*;
    logic MCLK = 1'b0;
    logic NRST = 1'b0;
    logic CONF_BUSY = 1'b0;
    logic CFG_READY = 1'b0;
    logic [7:0] PIN_IN = 8'h5a;
    logic [7:0] PROBE = 8'ha6;
    wire TCK, TMS, TDI, TDO, TDO_OE, PIN_DRIVE, CFG_VALID;
    wire [7:0] PIN_OUT;
    wire [31:0] CFG_DATA;
    logic [31:0] got_q[$];
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    always #50 MCLK = ~MCLK;
    bst_port #(.PIN_W(8), .PROBE_W(8)) u_bst_port (
        .MCLK(MCLK), .NRST(NRST), .TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO(TDO),
        .TDO_OE(TDO_OE), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_DRIVE(PIN_DRIVE),
        .CONF_BUSY(CONF_BUSY), .PROBE(PROBE), .CFG_VALID(CFG_VALID),
        .CFG_READY(CFG_READY), .CFG_DATA(CFG_DATA));
    bst_jtag_ctl u_bst_jtag_ctl (.TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO(TDO));
    // Loader side takes words; cycle ceiling cuts a hang short
    always @(posedge MCLK) begin
        cyc++;
        if (CFG_VALID === 1'b1 && CFG_READY === 1'b1)
            got_q.push_back(CFG_DATA);
        if (cyc == 6000) begin
            fails++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [39:0] exp, input logic [39:0] act);
        checks++;
        if (act !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, act);
        end
    endtask
    task automatic ir(input logic [3:0] op);
        logic [39:0] o;
        u_bst_jtag_ctl.scan(1'b1, IR_W, 40'(op), o);
        cmp("ir capture", 40'(IR_CAPTURE), o);
    endtask
    // One bit past the length shows the register's length
    task automatic t_dr(input string what, input logic [3:0] op, input int n,
                        input logic [39:0] exp);
        logic [39:0] o;
        ir(op);
        u_bst_jtag_ctl.scan(1'b0, n + 1, 40'h1, o);
        cmp(what, (exp & ((40'h1 << n) - 40'h1)) | (40'h1 << n), o);
    endtask
    task automatic t_regs();
        t_dr("idcode", OP_IDCODE, ID_W, 40'(ID_DEFAULT));
        t_dr("usercode", OP_USERCODE, USER_W, 40'(USER_DEFAULT));
        t_dr("bypass", OP_BYPASS, BYP_W, 40'h0);
        t_dr("unknown op", 4'h3, BYP_W, 40'h0);
        t_dr("probes", OP_LA_PROBE, 8, 40'(PROBE));
        t_dr("sample", OP_SAMPLE, 16, 40'({PROBE, PIN_IN}));
    endtask
    task automatic t_extest();
        logic [39:0] o;
        ir(OP_SAMPLE);
        u_bst_jtag_ctl.scan(1'b0, 16, 40'h3c, o);
        @(posedge MCLK) PIN_IN <= 8'h96;
        ir(OP_EXTEST);
        cmp("preload drive", 40'h13c, 40'({PIN_DRIVE, PIN_OUT}));
        u_bst_jtag_ctl.scan(1'b0, 16, 40'hc3, o);
        cmp("extest capture", 40'h96, o & 40'hff);
        cmp("extest drive", 40'h1c3, 40'({PIN_DRIVE, PIN_OUT}));
        ir(OP_BYPASS);
        cmp("bypass release", 40'h0, 40'(PIN_DRIVE));
    endtask
    // Busy turns scan testing off, pins released within the eight idle cycles that follow
    task automatic t_busy();
        ir(OP_EXTEST);
        @(posedge MCLK) CONF_BUSY <= 1'b1;
        u_bst_jtag_ctl.idle(8, 1'b0);
        cmp("busy drive", 40'h0, 40'(PIN_DRIVE));
        t_dr("busy sample", OP_SAMPLE, BYP_W, 40'h0);
        @(posedge MCLK) CONF_BUSY <= 1'b0;
        t_dr("idle sample", OP_SAMPLE, 16, 40'({PROBE, PIN_IN}));
    endtask
    // Loader stalls until the path refuses, then drains it
    task automatic t_cfg();
        logic [39:0] o;
        logic [31:0] w;
        logic [31:0] acc[$];
        ir(OP_CFG_LOAD);
        for (int k = 0; k < 13; k++) begin
            if (k == 12) begin
                @(posedge MCLK) CFG_READY <= 1'b1;
                u_bst_jtag_ctl.idle(100, 1'b0);
            end
            w = 32'h5a00_0000 + 32'(k);
            u_bst_jtag_ctl.scan(1'b0, CFG_W, 40'(w), o);
            if (o[0] === 1'b0)
                acc.push_back(w);
            u_bst_jtag_ctl.idle(60, 1'b0);
        end
        repeat (20) @(posedge MCLK);
        cmp("cfg fill", 40'h1, 40'(acc.size() > FIFO_DEPTH && acc.size() < 13));
        cmp("cfg count", 40'(acc.size()), 40'(got_q.size()));
        foreach (acc[i]) cmp("cfg word", 40'(acc[i]), 40'(got_q[i]));
    endtask
    initial begin
        fork
            u_bst_jtag_ctl.idle(140, 1'b1);
            begin
                repeat (20) @(posedge MCLK);
                NRST <= 1'b1;
            end
        join
        u_bst_jtag_ctl.idle(2, 1'b0);
        t_regs();
        t_extest();
        t_busy();
        t_cfg();
        test_done();
    end
endmodule
`default_nettype wire
